// ---- verilog/pfmux_defs.svh ----
/*
 * Register offsets, field positions, reset values and the unlock key
 * of the pin function multiplexer.
 * Assumes a 12-bit byte address and 32-bit APB data.
 */
`ifndef PFMUX_DEFS_SVH
`define PFMUX_DEFS_SVH

`define PFMUX_OFF_COMPAT   12'h00C
`define PFMUX_OFF_RSV3     12'h010
`define PFMUX_OFF_CAMSER   12'h014
`define PFMUX_OFF_CAMDAT   12'h018
`define PFMUX_OFF_STATUS   12'h01C

`define PFMUX_UNLOCK_KEY   32'h0000EAEF
`define PFMUX_RESET_WORD   32'h00000000
`define PFMUX_KEY_W        16
`define PFMUX_SEL_W        3
`define PFMUX_SEL_DEFAULT  3'h0

`define PFMUX_CAMSER_MASK  32'h3FE3F000
`define PFMUX_CAMDAT_MASK  32'h3FFFFFFF

`define PFMUX_CAM_D7_LSB   27
`define PFMUX_CAMERA_LINE_CLOCK_PIN_LSB 24
`define PFMUX_CAM_XCLK_LSB 21
`define PFMUX_SER_TXD_LSB  15
`define PFMUX_SER_TXS_LSB  12
`define PFMUX_CAM_RST_LSB  27
`define PFMUX_CAMERA_HSYNC_PIN_LSB   24
`define PFMUX_CAMERA_VSYNC_PIN_LSB   21
`define PFMUX_CAM_D0_LSB   18

`endif

// ---- verilog/pfmux_pkg.sv ----
/*
 * Types and helper functions of the pin function multiplexer.
 * Assumes pfmux_defs.svh is on the include path.
 */
`include "pfmux_defs.svh"

package pfmux_pkg;

   typedef enum logic [1:0] {
      mode_compat = 2'b01,
      mode_native = 2'b10
   } pfmux_mode_t;

   typedef enum logic [2:0] {
      reg_none   = 3'h0,
      reg_compat = 3'h1,
      reg_rsv3   = 3'h2,
      reg_camser = 3'h3,
      reg_camdat = 3'h4,
      reg_status = 3'h5
   } pfmux_reg_t;

   typedef struct packed {
      logic [2:0]      cam_data7;
      logic [2:0]      cam_line_clock;
      logic [2:0]      cam_ext_clock;
      logic [2:0]      serial_tx_data;
      logic [2:0]      serial_tx_sync;
      logic [2:0]      cam_reset;
      logic [2:0]      cam_hsync;
      logic [2:0]      cam_vsync;
      logic [6:0][2:0] cam_data;
   } pfmux_sel_t;

   typedef struct packed {
      logic        valid;
      pfmux_reg_t  sel;
      logic [31:0] data;
   } pfmux_wr_t;

   // Byte address to register; misaligned or unknown gives reg_none
   function automatic pfmux_reg_t pfmux_decode(input logic [11:0] a);
      case (a)
         `PFMUX_OFF_COMPAT: pfmux_decode = reg_compat;
         `PFMUX_OFF_RSV3:   pfmux_decode = reg_rsv3;
         `PFMUX_OFF_CAMSER: pfmux_decode = reg_camser;
         `PFMUX_OFF_CAMDAT: pfmux_decode = reg_camdat;
         `PFMUX_OFF_STATUS: pfmux_decode = reg_status;
         default:           pfmux_decode = reg_none;
      endcase
   endfunction : pfmux_decode

   // One 3-bit select field out of a register word
   function automatic logic [2:0] pfmux_field(input logic [31:0] w,
                                              input int lsb);
      pfmux_field = w[lsb +: 3];
   endfunction : pfmux_field

endpackage : pfmux_pkg

// ---- verilog/pfmux_apb_slave.sv ----
/*
 * APB slave front end: decodes the address, makes write strobes and
 * the read capture pulse, answers pready and pslverr.
 * Assumes a zero-wait slave; pready follows the clock enable.
 */
`timescale 1ns/1ps

module pfmux_apb_slave (
   input  wire logic               pce,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic                    pready,
   output logic                    pslverr,
   output pfmux_pkg::pfmux_wr_t    wr,
   output logic                    rd_setup,
   output pfmux_pkg::pfmux_reg_t   rd_sel
);

   pfmux_pkg::pfmux_reg_t hit;

   always_comb begin
      hit      = pfmux_pkg::pfmux_decode(paddr);
      pready   = pce;
      pslverr  = psel && penable && (hit == pfmux_pkg::reg_none);
      wr.valid = psel && penable && pwrite && pce &&
                 (hit != pfmux_pkg::reg_none);
      wr.sel   = hit;
      wr.data  = pwdata;
      rd_setup = psel && !penable && !pwrite && pce;
      rd_sel   = hit;
   end

endmodule : pfmux_apb_slave

// ---- verilog/pfmux_sel_gate.sv ----
/*
 * Splits the two select registers into pin fields and forces every
 * field to its default while the block is not unlocked.
 * Assumes the mode comes from the control register logic.
 */
`timescale 1ns/1ps
`include "pfmux_defs.svh"

module pfmux_sel_gate (
   input  pfmux_pkg::pfmux_mode_t mode,
   input  wire logic [31:0]       camser,
   input  wire logic [31:0]       camdat,
   output pfmux_pkg::pfmux_sel_t  eff
);

   pfmux_pkg::pfmux_sel_t raw;

   always_comb begin
      raw.cam_data7      = pfmux_pkg::pfmux_field(camser,
                                                  `PFMUX_CAM_D7_LSB);
      raw.cam_line_clock = pfmux_pkg::pfmux_field(camser,
                                                  `PFMUX_CAMERA_LINE_CLOCK_PIN_LSB);
      raw.cam_ext_clock  = pfmux_pkg::pfmux_field(camser,
                                                  `PFMUX_CAM_XCLK_LSB);
      raw.serial_tx_data = pfmux_pkg::pfmux_field(camser,
                                                  `PFMUX_SER_TXD_LSB);
      raw.serial_tx_sync = pfmux_pkg::pfmux_field(camser,
                                                  `PFMUX_SER_TXS_LSB);
      raw.cam_reset      = pfmux_pkg::pfmux_field(camdat,
                                                  `PFMUX_CAM_RST_LSB);
      raw.cam_hsync      = pfmux_pkg::pfmux_field(camdat,
                                                  `PFMUX_CAMERA_HSYNC_PIN_LSB);
      raw.cam_vsync      = pfmux_pkg::pfmux_field(camdat,
                                                  `PFMUX_CAMERA_VSYNC_PIN_LSB);
      for (int i = 0; i < 7; i++) begin
         raw.cam_data[i] = pfmux_pkg::pfmux_field(camdat,
                              `PFMUX_CAM_D0_LSB - 3 * i);
      end
      // Forced default outside native mode
      eff = (mode == pfmux_pkg::mode_native) ? raw : '0;
   end

endmodule : pfmux_sel_gate

// ---- verilog/pfmux_top.sv ----
/*
 * Pin function multiplexer with compatibility unlock: APB register
 * file, unlock state machine and registered pin selections.
 * Assumes one clock, APB master on the same clock, and that the pin
 * selections feed the pad multiplexers directly.
 */
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "pfmux_defs.svh"

// Contract
// - Reset starts in compatibility mode; new selects have no effect.
// - Writing key 0x0000EAEF to control unlocks registers at 0x10 and up.
// - Key field bits 15..0 read/write; bits 31..16 read zero.
// - Effective selects are 000 in reset and compatibility mode.
// - Register 4 bits 29..21: camera data7, line clock, external clock.
// - Register 4 bits 17..12: serial transmit data and frame sync.
// - Register 5 bits 29..21: camera reset, hsync, vsync selects.
// - Register 5 bits 20..0: camera data 0 to 6, data 0 in bits 20..18, data 6 in bits 2..0.
// - Select fields read back as written, reset to zero.
module pfmux_top #(
   parameter logic [31:0] UNLOCK_KEY = `PFMUX_UNLOCK_KEY
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              pce,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic                   unlocked,
   output pfmux_pkg::pfmux_sel_t  pin_select
);

   if (UNLOCK_KEY[31:16] != 16'h0000) begin : g_key_check
      $error("Unlock key must fit the 16-bit key field");
   end

   pfmux_pkg::pfmux_wr_t   wr;
   logic                   rd_setup;
   pfmux_pkg::pfmux_reg_t  rd_sel;
   pfmux_pkg::pfmux_mode_t mode;
   pfmux_pkg::pfmux_mode_t next_mode;
   pfmux_pkg::pfmux_sel_t  eff;
   logic [15:0]            key_q;
   logic [31:0]            camser_q;
   logic [31:0]            camdat_q;
   logic [31:0]            next_rdata;
   logic                   key_wr;

   pfmux_apb_slave u_apb (
      .pce      (pce),
      .psel     (psel),
      .penable  (penable),
      .pwrite   (pwrite),
      .paddr    (paddr),
      .pwdata   (pwdata),
      .pready   (pready),
      .pslverr  (pslverr),
      .wr       (wr),
      .rd_setup (rd_setup),
      .rd_sel   (rd_sel)
   );

   pfmux_sel_gate u_gate (
      .mode   (mode),
      .camser (camser_q),
      .camdat (camdat_q),
      .eff    (eff)
   );

   // Full word must match, upper half zero included
   assign key_wr = wr.valid && (wr.sel == pfmux_pkg::reg_compat) &&
                   (wr.data == UNLOCK_KEY);

   // Unlock state machine
   always_comb begin
      case (mode)
         pfmux_pkg::mode_compat: begin
            next_mode = key_wr ? pfmux_pkg::mode_native
                               : pfmux_pkg::mode_compat;
         end
         pfmux_pkg::mode_native: begin
            next_mode = pfmux_pkg::mode_native;
         end
         default: begin
            next_mode = pfmux_pkg::mode_compat;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= pfmux_pkg::mode_compat;
      end else if (pce) begin
         mode <= next_mode;
      end
   end

   // Key field storage; upper half has no storage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_q <= 16'h0000;
      end else if (wr.valid && wr.sel == pfmux_pkg::reg_compat) begin
         key_q <= wr.data[`PFMUX_KEY_W-1:0];
      end
   end

   // Select registers; reserved bits are not stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         camser_q <= `PFMUX_RESET_WORD;
      end else if (wr.valid && wr.sel == pfmux_pkg::reg_camser) begin
         camser_q <= wr.data & `PFMUX_CAMSER_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         camdat_q <= `PFMUX_RESET_WORD;
      end else if (wr.valid && wr.sel == pfmux_pkg::reg_camdat) begin
         camdat_q <= wr.data & `PFMUX_CAMDAT_MASK;
      end
   end

   // Registered pin selections
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_select <= '0;
      end else if (pce) begin
         pin_select <= eff;
      end
   end

   assign unlocked = (mode == pfmux_pkg::mode_native);

   // Read data, captured in the setup cycle
   always_comb begin
      case (rd_sel)
         pfmux_pkg::reg_compat: begin
            next_rdata = {16'h0000, key_q};
         end
         pfmux_pkg::reg_camser: begin
            next_rdata = camser_q;
         end
         pfmux_pkg::reg_camdat: begin
            next_rdata = camdat_q;
         end
         pfmux_pkg::reg_status: begin
            next_rdata = {31'h0, unlocked};
         end
         default: begin
            next_rdata = 32'h00000000;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (rd_setup) begin
         prdata <= next_rdata;
      end
   end

   // Checks

   property p_stay_compat;
      @(posedge pclk) disable iff (!presetn)
      (mode == pfmux_pkg::mode_compat) && !key_wr
         |=> (mode == pfmux_pkg::mode_compat);
   endproperty
   a_stay_compat: assert property (p_stay_compat)
      else $error("Left compatibility mode without key");

   property p_unlock;
      @(posedge pclk) disable iff (!presetn)
      psel && penable && pwrite && pce &&
         (paddr == `PFMUX_OFF_COMPAT) && (pwdata == UNLOCK_KEY)
         |=> unlocked ##1 (pin_select == $past(eff));
   endproperty
   a_unlock: assert property (p_unlock)
      else $error("Key write did not unlock");

   property p_key_readback;
      @(posedge pclk) disable iff (!presetn)
      rd_setup && (rd_sel == pfmux_pkg::reg_compat)
         |=> (prdata[31:16] == 16'h0000) && (prdata[15:0] == key_q);
   endproperty
   a_key_readback: assert property (p_key_readback)
      else $error("Key register read back wrong");

   property p_forced_default;
      @(posedge pclk) disable iff (!presetn)
      !unlocked |=> (pin_select == '0);
   endproperty
   a_forced_default: assert property (p_forced_default)
      else $error("Select not forced while locked");

   property p_camser_fields;
      @(posedge pclk) disable iff (!presetn)
      unlocked && pce |=>
         (pin_select.cam_data7 == $past(camser_q[29:27])) &&
         (pin_select.cam_line_clock == $past(camser_q[26:24])) &&
         (pin_select.cam_ext_clock == $past(camser_q[23:21]));
   endproperty
   a_camser_fields: assert property (p_camser_fields)
      else $error("Camera select fields misplaced");

   property p_serial_fields;
      @(posedge pclk) disable iff (!presetn)
      unlocked && pce |=>
         (pin_select.serial_tx_data == $past(camser_q[17:15])) &&
         (pin_select.serial_tx_sync == $past(camser_q[14:12])) &&
         (camser_q[11:0] == 12'h000) && (camser_q[20:18] == 3'h0);
   endproperty
   a_serial_fields: assert property (p_serial_fields)
      else $error("Serial select fields misplaced");

   property p_camdat_fields;
      @(posedge pclk) disable iff (!presetn)
      unlocked && pce |=>
         (pin_select.cam_reset == $past(camdat_q[29:27])) &&
         (pin_select.cam_vsync == $past(camdat_q[23:21])) &&
         (pin_select.cam_data[0] == $past(camdat_q[20:18])) &&
         (pin_select.cam_data[6] == $past(camdat_q[2:0]));
   endproperty
   a_camdat_fields: assert property (p_camdat_fields)
      else $error("Camera data select fields misplaced");

   property p_write_readback;
      @(posedge pclk) disable iff (!presetn)
      wr.valid && (wr.sel == pfmux_pkg::reg_camdat) ##2
         rd_setup && (rd_sel == pfmux_pkg::reg_camdat)
         |=> (prdata == ($past(wr.data, 3) & `PFMUX_CAMDAT_MASK));
   endproperty
   a_write_readback: assert property (p_write_readback)
      else $error("Select register read back wrong");

   property p_stay_native;
      @(posedge pclk) disable iff (!presetn)
      unlocked |=> unlocked [*2];
   endproperty
   a_stay_native: assert property (p_stay_native)
      else $error("Relocked without reset");

   property p_locked_no_effect;
      @(posedge pclk) disable iff (!presetn)
      !unlocked |-> (pin_select == '0);
   endproperty
   a_locked_no_effect: assert property (p_locked_no_effect)
      else $error("Select active while locked");

   property p_upper_key_refused;
      @(posedge pclk) disable iff (!presetn)
      wr.valid && (wr.sel == pfmux_pkg::reg_compat) &&
         (wr.data[31:16] != 16'h0000) && !unlocked |=> !unlocked;
   endproperty
   a_upper_key_refused: assert property (p_upper_key_refused)
      else $error("Unlocked with upper key bits set");

   property p_key_store;
      @(posedge pclk) disable iff (!presetn)
      wr.valid && (wr.sel == pfmux_pkg::reg_compat)
         |=> (key_q == $past(wr.data[15:0]));
   endproperty
   a_key_store: assert property (p_key_store)
      else $error("Key field not stored");

   property p_nonkey_keeps_mode;
      @(posedge pclk) disable iff (!presetn)
      wr.valid && (wr.sel == pfmux_pkg::reg_compat) &&
         (wr.data != UNLOCK_KEY) |=> (mode == $past(mode));
   endproperty
   a_nonkey_keeps_mode: assert property (p_nonkey_keeps_mode)
      else $error("Mode changed by a non-key write");

   property p_camser_store;
      @(posedge pclk) disable iff (!presetn)
      wr.valid && (wr.sel == pfmux_pkg::reg_camser)
         |=> (camser_q == ($past(wr.data) & `PFMUX_CAMSER_MASK));
   endproperty
   a_camser_store: assert property (p_camser_store)
      else $error("Register 4 write not stored");

   property p_camdat_store;
      @(posedge pclk) disable iff (!presetn)
      wr.valid && (wr.sel == pfmux_pkg::reg_camdat)
         |=> (camdat_q == ($past(wr.data) & `PFMUX_CAMDAT_MASK));
   endproperty
   a_camdat_store: assert property (p_camdat_store)
      else $error("Register 5 write not stored");

   property p_camdat_middle;
      @(posedge pclk) disable iff (!presetn)
      unlocked && pce |=>
         (pin_select.cam_hsync == $past(camdat_q[26:24])) &&
         (pin_select.cam_data[1] == $past(camdat_q[17:15])) &&
         (pin_select.cam_data[2] == $past(camdat_q[14:12])) &&
         (pin_select.cam_data[3] == $past(camdat_q[11:9])) &&
         (pin_select.cam_data[4] == $past(camdat_q[8:6])) &&
         (pin_select.cam_data[5] == $past(camdat_q[5:3]));
   endproperty
   a_camdat_middle: assert property (p_camdat_middle)
      else $error("Camera sync or data select misplaced");

   property p_freeze_state;
      @(posedge pclk) disable iff (!presetn)
      !pce |=> $stable(mode) && $stable(key_q) &&
         $stable(camser_q) && $stable(camdat_q);
   endproperty
   a_freeze_state: assert property (p_freeze_state)
      else $error("State changed while clock enable low");

   property p_freeze_out;
      @(posedge pclk) disable iff (!presetn)
      !pce |=> $stable(pin_select) && $stable(prdata);
   endproperty
   a_freeze_out: assert property (p_freeze_out)
      else $error("Outputs changed while clock enable low");

   property p_status_read;
      @(posedge pclk) disable iff (!presetn)
      rd_setup && (rd_sel == pfmux_pkg::reg_status)
         |=> (prdata == {31'h0, $past(unlocked)});
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("Status read back wrong");

   property p_rdata_hold;
      @(posedge pclk) disable iff (!presetn)
      !rd_setup |=> $stable(prdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("Read data changed outside a read");

   property p_rsv3_read;
      @(posedge pclk) disable iff (!presetn)
      rd_setup && (rd_sel == pfmux_pkg::reg_rsv3) |=> (prdata == 32'h0);
   endproperty
   a_rsv3_read: assert property (p_rsv3_read)
      else $error("Reserved register 3 read not zero");

endmodule : pfmux_top

// ---- dv/tb.sv ----
/*
 * Self-checking bench of the pin function multiplexer: APB master,
 * a reference model of the registers and the unlock, and the checks.
 * Assumes pfmux_defs.svh on the include path and one 125 MHz clock.
 */
`timescale 1ns/1ps

`define CHK(g, e, msg) begin \
   n_tests++; \
   if ((g) !== (e)) begin \
      errors++; \
      $display("CHECK FAILED at %0t: %s", $time, msg); \
   end \
end

module tb;
   logic                  pclk;
   logic                  presetn;
   logic                  pce;
   logic                  psel;
   logic                  penable;
   logic                  pwrite;
   logic [11:0]           paddr;
   logic [31:0]           pwdata;
   logic [31:0]           prdata;
   logic                  pready;
   logic                  pslverr;
   logic                  unlocked;
   pfmux_pkg::pfmux_sel_t pin_select;
   int                    errors;
   int                    n_tests;
   int                    seed;
   int                    cycles;
   logic [31:0]           m_key;
   logic [31:0]           m_r4;
   logic [31:0]           m_r5;
   logic                  m_unl;
   logic [31:0]           w;
   logic [11:0]           addrs[$];

   pfmux_top #(.UNLOCK_KEY(32'h0000EAEF)) dut (
      .pclk       (pclk),
      .presetn    (presetn),
      .pce        (pce),
      .psel       (psel),
      .penable    (penable),
      .pwrite     (pwrite),
      .paddr      (paddr),
      .pwdata     (pwdata),
      .prdata     (prdata),
      .pready     (pready),
      .pslverr    (pslverr),
      .unlocked   (unlocked),
      .pin_select (pin_select)
   );

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 6000) begin
         errors++;
         report_and_stop;
      end
   end

   function automatic logic mdl_err(input logic [11:0] a);
      return !(a inside {12'h00C, 12'h010, 12'h014, 12'h018, 12'h01C});
   endfunction : mdl_err

   function automatic logic [31:0] mdl_read(input logic [11:0] a);
      case (a)
         12'h00C: return m_key;
         12'h014: return m_r4;
         12'h018: return m_r5;
         12'h01C: return {31'h0, m_unl};
         default: return 32'h0;
      endcase
   endfunction : mdl_read

   function automatic void mdl_write(input logic [11:0] a,
                                     input logic [31:0] d);
      case (a)
         12'h00C: begin
            m_key = {16'h0000, d[15:0]};
            if (d == 32'h0000EAEF) m_unl = 1'b1;
         end
         12'h014: m_r4 = d & 32'h3FE3F000;
         12'h018: m_r5 = d & 32'h3FFFFFFF;
         default: ;
      endcase
   endfunction : mdl_write

   function automatic pfmux_pkg::pfmux_sel_t exp_sel();
      pfmux_pkg::pfmux_sel_t e;
      e = '0;
      if (m_unl) begin
         e.cam_data7      = m_r4[29:27];
         e.cam_line_clock = m_r4[26:24];
         e.cam_ext_clock  = m_r4[23:21];
         e.serial_tx_data = m_r4[17:15];
         e.serial_tx_sync = m_r4[14:12];
         e.cam_reset      = m_r5[29:27];
         e.cam_hsync      = m_r5[26:24];
         e.cam_vsync      = m_r5[23:21];
         for (int i = 0; i < 7; i++) begin
            e.cam_data[i] = m_r5[20-3*i -: 3];
         end
      end
      return e;
   endfunction : exp_sel

   task automatic xfer(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
      logic [31:0] rd;
      logic        rdy;
      logic        er;
      int          st;
      st = $random(seed) & 3;
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      pce     <= (st == 0);
      forever begin
         @(posedge pclk);
         rdy = pready;
         rd  = prdata;
         er  = pslverr;
         if (st > 0) `CHK(rdy, 1'b0, "pready while clock disabled")
         if (rdy === 1'b1) break;
         st--;
         pce <= (st == 0);
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      `CHK(er, mdl_err(a), "slave error")
      if (!wr) begin
         `CHK(rd, mdl_read(a), "read data")
      end else begin
         mdl_write(a, d);
      end
      @(posedge pclk);
   endtask : xfer

   task automatic check_pins;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      `CHK(unlocked, m_unl, "mode")
      `CHK(pin_select, exp_sel(), "pin selects")
      @(posedge pclk);
   endtask : check_pins

   task automatic do_reset;
      presetn <= 1'b0;
      m_key = 32'h0;
      m_r4  = 32'h0;
      m_r5  = 32'h0;
      m_unl = 1'b0;
      repeat (8) @(posedge pclk);
      `CHK(unlocked, 1'b0, "mode in reset")
      `CHK(pin_select, exp_sel(), "selects in reset")
      presetn <= 1'b1;
      @(posedge pclk);
   endtask : do_reset

   task automatic rand_round;
      xfer(1'b1, 12'h014, $random(seed) & 32'h3FE3F000);
      xfer(1'b1, 12'h018, $random(seed) & 32'h3FFFFFFF);
      xfer(1'b1, 12'h010, 32'h0);
      xfer(1'b1, 12'h020, $random(seed));
      xfer(1'b1, 12'h00C, {16'h0000, 16'(($random(seed) & 32'h7FFF))});
      foreach (addrs[i]) xfer(1'b0, addrs[i], 32'h0);
      check_pins;
   endtask : rand_round

   initial begin
      seed    = 89;
      errors  = 0;
      n_tests = 0;
      cycles  = 0;
      presetn = 1'b0;
      pce     = 1'b1;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0;
      addrs   = '{12'h00C, 12'h010, 12'h014, 12'h018, 12'h01C,
                  12'h000, 12'h015, 12'h020};
      do_reset;
      foreach (addrs[i]) xfer(1'b0, addrs[i], 32'h0);
      repeat (6) rand_round;
      xfer(1'b1, 12'h00C, 32'h0001EAEF);
      xfer(1'b1, 12'h00C, 32'h0000EAEE);
      check_pins;
      xfer(1'b1, 12'h00C, 32'h0000EAEF);
      check_pins;
      repeat (6) rand_round;
      for (int v = 0; v < 8; v++) begin
         w = 32'h0;
         for (int k = 0; k < 10; k++) w[3*k +: 3] = 3'(v);
         xfer(1'b1, 12'h014, w & 32'h3FE3F000);
         xfer(1'b1, 12'h018, w);
         xfer(1'b0, 12'h018, 32'h0);
         check_pins;
      end
      do_reset;
      foreach (addrs[i]) xfer(1'b0, addrs[i], 32'h0);
      check_pins;
      report_and_stop;
   end
endmodule : tb
